// ---- shared/gfs_pkg.sv ----
package gfs_pkg;
  // Widths of measured quantities
  localparam int POS_W  = 16;
  localparam int TEMP_W = 12;
  localparam int VOLT_W = 12;
  localparam int TS_W   = 32;

  // Host command codes
  localparam logic [7:0] CMD_ACK       = 8'h24;
  localparam logic [7:0] CMD_PREPOS    = 8'h21;
  localparam logic [7:0] CMD_GRASP     = 8'h25;
  localparam logic [7:0] CMD_RELEASE   = 8'h26;
  localparam logic [7:0] CMD_STOP      = 8'h22;

  // Answer codes
  localparam logic [7:0] ANS_OK        = 8'h00;
  localparam logic [7:0] ANS_DENIED    = 8'h01;
  localparam logic [7:0] ANS_RANGE     = 8'h02;
  localparam logic [7:0] ANS_REFUSED   = 8'h03;

  // Thresholds: temperature in 0.1 degC, voltage in 0.1 V
  localparam logic [11:0] TEMP_WARN    = 12'h0_28A;  // 65.0 degC
  localparam logic [11:0] TEMP_ERR     = 12'h0_2BC;  // 70.0 degC
  localparam logic [11:0] VOLT_LO_ERR  = 12'h0_0C8;  // 20.0 V
  localparam logic [11:0] VOLT_LO_WARN = 12'h0_0DC;  // 22.0 V
  localparam logic [11:0] VOLT_HI_WARN = 12'h0_104;  // 26.0 V
  localparam logic [11:0] VOLT_HI_ERR  = 12'h0_118;  // 28.0 V
  localparam logic [11:0] VOLT_RST     = 12'h0_0F0;  // 24.0 V, in band: no false warning
  localparam logic [11:0] HYST_DEF     = 12'h0_005;  // 5 units: 0.5 degC or 0.5 V

  // Millisecond tick
  localparam int CLK_HZ        = 10_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int LOG_DEPTH_DEF = 16;

  // Event causes
  localparam logic [3:0] EV_LIMIT   = 4'h1;
  localparam logic [3:0] EV_TWARN   = 4'h2;
  localparam logic [3:0] EV_TERR    = 4'h3;
  localparam logic [3:0] EV_CURR    = 4'h4;
  localparam logic [3:0] EV_SUPPLY  = 4'h5;
  localparam logic [3:0] EV_GRIPERR = 4'h6;

  typedef enum logic [2:0] {
    GS_IDLE, GS_GRASPING, GS_HOLDING, GS_PART_LOST,
    GS_NO_PART, GS_RELEASING, GS_POSITIONING, GS_ERROR
  } gfs_grip_t;

  // One host request
  typedef struct packed {
    logic             valid;
    logic [7:0]       code;
    logic [POS_W-1:0] target;
  } gfs_cmd_t;

  // One answer
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } gfs_ans_t;

  // One log entry
  typedef struct packed {
    logic [TS_W-1:0] stamp;
    logic [3:0]      cause;
  } gfs_log_t;
endpackage : gfs_pkg

// ---- core/gfs_supervisor.sv ----
`timescale 1ns/1ps
// Functional notes
// [R1] Grip valid only if width in nominal+tolerance..clamping window.
// [R2] Grasp ending with no part goes to no-part-found state.
// [R3] Contact outside window is axis block; grip state becomes error.
// [R4] Pre-position moves disable part detection and grip monitoring.
// [R5] Maximum tolerance equal to full travel disables axis-block detection.
// [R6] Targets in active forbidden zone get range error, not executed.
// [R7] Crossing into active forbidden zone during motion raises fast stop.
// [R8] Already inside a zone at activation: only moves leaving it allowed.
// [R9] Any fast stop sets the fast-stop flag.
// [R10] After fast stop, motion denied until acknowledged and cause cleared.
// [R11] Fast stop removes drive power, keeps homed reference.
// [R12] Acknowledge by command 24h or by the web acknowledge input.
// [R13] Fast stops, temperature and current events go to event log.
// [R14] Log entries stamped with milliseconds since start.
// [R15] Full log overwrites oldest entry, circular.
// [R16] Temperature above 65 degC gives warning.
// [R17] At 70 degC temperature error and fast stop.
// [R18] Ack refused while temperature error persists.
// [R19] Overcurrent gives fast stop and current fault; ack refused meanwhile.
// [R20] Supply at or below 22 V warns, at or below 20 V faults.
// [R21] Supply at or above 26 V warns, at or above 28 V faults.
// [R22] Supply states use hysteresis; supply fault fast stops, ack when in range.
// [R23] Stop outside error state aborts and returns to idle at once.
// [R24] Grip error needing ack sets fast-stop flag; restart after ack.
// [R25] Hysteresis width is a configurable parameter.
module gfs_supervisor #(
  parameter int                        LOG_DEPTH = gfs_pkg::LOG_DEPTH_DEF,
  parameter logic [gfs_pkg::VOLT_W-1:0] HYST     = gfs_pkg::HYST_DEF
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  // Host command and answer
  input  wire gfs_pkg::gfs_cmd_t            hostCmd,
  output gfs_pkg::gfs_ans_t                 hostAns,
  input  wire logic                         webAck,
  // Grip configuration
  input  wire logic [gfs_pkg::POS_W-1:0]    nominalWidth,
  input  wire logic [gfs_pkg::POS_W-1:0]    widthTolerance,
  input  wire logic [gfs_pkg::POS_W-1:0]    clampTravel,
  input  wire logic [gfs_pkg::POS_W-1:0]    fullTravel,
  // Software limits
  input  wire logic                         innerLimitOn,
  input  wire logic [gfs_pkg::POS_W-1:0]    innerLimit,
  input  wire logic                         outerLimitOn,
  input  wire logic [gfs_pkg::POS_W-1:0]    outerLimit,
  // Motion feedback from the drive
  input  wire logic [gfs_pkg::POS_W-1:0]    fingerPos,
  input  wire logic                         contactSeen,
  input  wire logic                         motionDone,
  input  wire logic                         forceLost,
  // Measurements
  input  wire logic [gfs_pkg::TEMP_W-1:0]   housingTemp,
  input  wire logic [gfs_pkg::VOLT_W-1:0]   supplyVolt,
  input  wire logic                         overCurrent,
  // Status outputs
  output gfs_pkg::gfs_grip_t                gripState,
  output logic                              halt_latched_flag,
  output logic                              supply_fault_flag,
  output logic                              supply_warning_flag,
  output logic                              tempWarnFlag,
  output logic                              tempErrFlag,
  output logic                              currentFaultFlag,
  output logic                              drivePowerOn,
  output logic                              monitorActive,
  // Event log read port
  input  wire logic [$clog2(LOG_DEPTH)-1:0] logReadIdx,
  output gfs_pkg::gfs_log_t                 logReadData,
  output logic [$clog2(LOG_DEPTH)-1:0]      logWritePtr,
  output logic                              logWrapped
);
  localparam int PW = $clog2(LOG_DEPTH);

  // Two-flop synchronisers for the overcurrent, contact and force-lost pins
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic       overCurS;
  logic       contactS;
  logic       forceLostS;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {overCurrent, contactSeen, forceLost};
      syncB <= syncA;
    end
  end
  assign {overCurS, contactS, forceLostS} = syncB;

  logic [gfs_pkg::TEMP_W-1:0] tempS1;
  logic [gfs_pkg::TEMP_W-1:0] tempS;
  logic [gfs_pkg::VOLT_W-1:0] voltS1;
  logic [gfs_pkg::VOLT_W-1:0] voltS;
  logic [gfs_pkg::POS_W-1:0]  posS1;
  logic [gfs_pkg::POS_W-1:0]  posS;
  // Measurement words sampled twice; sensors update slowly
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tempS1 <= '0;
      tempS  <= '0;
      voltS1 <= gfs_pkg::VOLT_RST;
      voltS  <= gfs_pkg::VOLT_RST;
      posS1  <= '0;
      posS   <= '0;
    end else begin
      tempS1 <= housingTemp;
      tempS  <= tempS1;
      voltS1 <= supplyVolt;
      voltS  <= voltS1;
      posS1  <= fingerPos;
      posS   <= posS1;
    end
  end

  // Temperature monitor with hysteresis on release
  // [R16] [R17] [R25] temperature thresholds
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tempWarnFlag <= 1'b0;
      tempErrFlag  <= 1'b0;
    end else begin
      if (tempS > gfs_pkg::TEMP_WARN)
        tempWarnFlag <= 1'b1;
      else if (tempS + HYST <= gfs_pkg::TEMP_WARN)
        tempWarnFlag <= 1'b0;
      if (tempS >= gfs_pkg::TEMP_ERR)
        tempErrFlag <= 1'b1;
      else if (tempS + HYST < gfs_pkg::TEMP_ERR)
        tempErrFlag <= 1'b0;
    end
  end

  // Supply monitor; hysteresis stops chatter near a threshold
  // [R20] [R21] [R22] supply bands
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      supply_warning_flag <= 1'b0;
      supply_fault_flag   <= 1'b0;
    end else begin
      if (voltS <= gfs_pkg::VOLT_LO_WARN || voltS >= gfs_pkg::VOLT_HI_WARN)
        supply_warning_flag <= 1'b1;
      else if (voltS > gfs_pkg::VOLT_LO_WARN + HYST && voltS + HYST < gfs_pkg::VOLT_HI_WARN)
        supply_warning_flag <= 1'b0;
      if (voltS <= gfs_pkg::VOLT_LO_ERR || voltS >= gfs_pkg::VOLT_HI_ERR)
        supply_fault_flag <= 1'b1;
      else if (voltS > gfs_pkg::VOLT_LO_ERR + HYST && voltS + HYST < gfs_pkg::VOLT_HI_ERR)
        supply_fault_flag <= 1'b0;
    end
  end

  // Current fault follows the synchronised overcurrent pin
  // [R19] current fault flag
  always_ff @(posedge clk) begin
    if (!reset_n)
      currentFaultFlag <= 1'b0;
    else
      currentFaultFlag <= overCurS;
  end

  // Forbidden zone checks
  logic inInner;
  logic inOuter;
  logic tgtForbidden;
  logic cmdIsMove;
  logic cmdLeavesZone;
  assign inInner = innerLimitOn && (posS < innerLimit);
  assign inOuter = outerLimitOn && (posS > outerLimit);
  assign tgtForbidden = (innerLimitOn && hostCmd.target < innerLimit)
                     || (outerLimitOn && hostCmd.target > outerLimit);
  assign cmdIsMove = hostCmd.code == gfs_pkg::CMD_PREPOS
                  || hostCmd.code == gfs_pkg::CMD_GRASP
                  || hostCmd.code == gfs_pkg::CMD_RELEASE;
  // [R8] escape moves only
  assign cmdLeavesZone = (inInner && hostCmd.target > posS)
                      || (inOuter && hostCmd.target < posS);

  // Limit crossing while moving; escape from a zone is allowed
  logic moving;
  logic escaping;
  logic limitCross;
  assign moving = gripState == gfs_pkg::GS_GRASPING
               || gripState == gfs_pkg::GS_RELEASING
               || gripState == gfs_pkg::GS_POSITIONING;
  // [R7] crossing into zone
  assign limitCross = moving && !escaping && (inInner || inOuter);

  // Grip window check
  logic [gfs_pkg::POS_W:0] winHi;
  logic [gfs_pkg::POS_W:0] winLo;
  logic [gfs_pkg::POS_W:0] winSpan;
  logic                    inWindow;
  logic                    blockCheck;
  assign winHi = {1'b0, nominalWidth} + {1'b0, widthTolerance};
  // Floor at zero; a wide tolerance must not wrap the lower edge
  assign winSpan = {1'b0, widthTolerance} + {1'b0, clampTravel};
  assign winLo = ({1'b0, nominalWidth} > winSpan) ? {1'b0, nominalWidth} - winSpan : '0;
  // [R1] valid grip window
  assign inWindow = ({1'b0, posS} <= winHi) && ({1'b0, posS} >= winLo);
  // [R5] tolerance at full range
  assign blockCheck = widthTolerance < fullTravel;
  logic axisBlock;
  assign axisBlock = gripState == gfs_pkg::GS_GRASPING && contactS && !inWindow && blockCheck;

  // New fast stop causes
  logic haltCause;
  logic causeActive;
  assign haltCause = limitCross || tempErrFlag || currentFaultFlag || supply_fault_flag
                  || axisBlock;
  // [R18] [R19] [R22] cause must be gone
  assign causeActive = tempErrFlag || currentFaultFlag || supply_fault_flag;

  logic ackReq;
  logic ackOk;
  // [R12] host 24h or web
  assign ackReq = (hostCmd.valid && hostCmd.code == gfs_pkg::CMD_ACK) || webAck;
  assign ackOk = ackReq && halt_latched_flag && !causeActive;

  // Fast-stop latch; a new cause wins over a same-cycle ack
  // [R9] [R10] [R24] fast-stop flag
  always_ff @(posedge clk) begin
    if (!reset_n)
      halt_latched_flag <= 1'b0;
    else if (haltCause)
      halt_latched_flag <= 1'b1;
    else if (ackOk)
      halt_latched_flag <= 1'b0;
  end

  // Drive power off during fast stop; position reference untouched
  // [R11] power removal
  always_ff @(posedge clk) begin
    if (!reset_n)
      drivePowerOn <= 1'b0;
    else
      drivePowerOn <= !(halt_latched_flag || haltCause);
  end

  // Command answers
  // [R6] [R10] refusal codes
  always_ff @(posedge clk) begin
    if (!reset_n)
      hostAns <= '0;
    else begin
      hostAns.valid <= hostCmd.valid;
      if (!hostCmd.valid)
        hostAns.code <= gfs_pkg::ANS_OK;
      else if (hostCmd.code == gfs_pkg::CMD_ACK)
        hostAns.code <= ackOk ? gfs_pkg::ANS_OK : gfs_pkg::ANS_REFUSED;
      else if (cmdIsMove && (halt_latched_flag || haltCause))
        hostAns.code <= gfs_pkg::ANS_DENIED;
      else if (cmdIsMove && tgtForbidden && !cmdLeavesZone)
        hostAns.code <= gfs_pkg::ANS_RANGE;
      else
        hostAns.code <= gfs_pkg::ANS_OK;
    end
  end

  logic moveAccept;
  assign moveAccept = hostCmd.valid && cmdIsMove && !halt_latched_flag && !haltCause
                   && (!tgtForbidden || cmdLeavesZone);

  // Remember a move started from inside a zone toward its exit
  always_ff @(posedge clk) begin
    if (!reset_n)
      escaping <= 1'b0;
    else if (moveAccept)
      escaping <= cmdLeavesZone;
    else if (!inInner && !inOuter)
      escaping <= 1'b0;
  end

  // Grip state machine
  // [R4] monitors off when positioning
  always_ff @(posedge clk) begin
    if (!reset_n)
      monitorActive <= 1'b0;
    else
      monitorActive <= gripState == gfs_pkg::GS_GRASPING || gripState == gfs_pkg::GS_HOLDING;
  end

  always_ff @(posedge clk) begin
    if (!reset_n)
      gripState <= gfs_pkg::GS_IDLE;
    else if (haltCause && moving)
      gripState <= gfs_pkg::GS_ERROR;
    // [R23] stop aborts to idle
    else if (hostCmd.valid && hostCmd.code == gfs_pkg::CMD_STOP
             && gripState != gfs_pkg::GS_ERROR)
      gripState <= gfs_pkg::GS_IDLE;
    else begin
      case (gripState)
        gfs_pkg::GS_ERROR: begin
          // [R24] restart after ack
          if (ackOk || (!halt_latched_flag && moveAccept))
            gripState <= gfs_pkg::GS_IDLE;
        end
        gfs_pkg::GS_GRASPING: begin
          // [R3] axis block
          if (axisBlock)
            gripState <= gfs_pkg::GS_ERROR;
          else if (contactS && inWindow)
            gripState <= gfs_pkg::GS_HOLDING;
          // [R2] no part found
          else if (motionDone)
            gripState <= gfs_pkg::GS_NO_PART;
        end
        gfs_pkg::GS_HOLDING: begin
          if (moveAccept && hostCmd.code == gfs_pkg::CMD_RELEASE)
            gripState <= gfs_pkg::GS_RELEASING;
          else if (forceLostS)
            gripState <= gfs_pkg::GS_PART_LOST;
        end
        gfs_pkg::GS_RELEASING,
        gfs_pkg::GS_POSITIONING: begin
          if (motionDone)
            gripState <= gfs_pkg::GS_IDLE;
        end
        default: begin
          if (moveAccept && hostCmd.code == gfs_pkg::CMD_GRASP)
            gripState <= gfs_pkg::GS_GRASPING;
          else if (moveAccept && hostCmd.code == gfs_pkg::CMD_PREPOS)
            gripState <= gfs_pkg::GS_POSITIONING;
          else if (moveAccept && hostCmd.code == gfs_pkg::CMD_RELEASE)
            gripState <= gfs_pkg::GS_RELEASING;
        end
      endcase
    end
  end

  // Millisecond timestamp since reset
  // [R14] ms timestamp
  logic [$clog2(gfs_pkg::CYC_PER_MS)-1:0] msDiv;
  logic [gfs_pkg::TS_W-1:0]              msCount;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      msDiv   <= '0;
      msCount <= '0;
    end else if (msDiv == $bits(msDiv)'(gfs_pkg::CYC_PER_MS - 1)) begin
      msDiv   <= '0;
      msCount <= msCount + 1'b1;
    end else
      msDiv <= msDiv + 1'b1;
  end

  // Rising edges of the logged conditions
  logic [5:0] evNow;
  logic [5:0] evPrev;
  logic [5:0] evRise;
  // [R13] logged events
  assign evNow = {axisBlock, supply_fault_flag, currentFaultFlag, tempErrFlag,
                  tempWarnFlag, limitCross};
  assign evRise = evNow & ~evPrev;
  always_ff @(posedge clk) begin
    if (!reset_n)
      evPrev <= '0;
    else
      evPrev <= evNow;
  end

  // Lowest bit wins when several rise together; others are rare
  logic [3:0] evCause;
  always_comb begin
    evCause = '0;
    for (int i = 5; i >= 0; i--) begin
      if (evRise[i])
        evCause = 4'(i + 1);
    end
  end

  // Circular log; pointer wraps onto the oldest entry
  // [R15] overwrite oldest
  gfs_pkg::gfs_log_t logMem [LOG_DEPTH];
  always_ff @(posedge clk) begin
    if (evRise != '0)
      logMem[logWritePtr] <= '{stamp: msCount, cause: evCause};
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      logWritePtr <= '0;
      logWrapped  <= 1'b0;
    end else if (evRise != '0) begin
      logWritePtr <= (logWritePtr == PW'(LOG_DEPTH - 1)) ? '0 : logWritePtr + 1'b1;
      if (logWritePtr == PW'(LOG_DEPTH - 1))
        logWrapped <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n)
      logReadData <= '0;
    else
      logReadData <= logMem[logReadIdx];
  end
endmodule : gfs_supervisor

// ---- test/gfs_host_model.sv ----
`timescale 1ns/1ps
module gfs_host_model (
  // Clock
  input  wire logic              clk,
  // Request out, answer in
  output gfs_pkg::gfs_cmd_t      hostCmd,
  input  wire gfs_pkg::gfs_ans_t hostAns
);
  // Idle between requests
  initial hostCmd = '0;

  // Held over one taking edge; answer sampled a cycle later
  task automatic issue(input logic [7:0] code, input logic [15:0] tgt, output logic [7:0] ans);
    @(negedge clk);
    hostCmd = '{1'b1, code, tgt};
    @(negedge clk);
    // Answer stands only in the cycle after the taking edge
    ans = hostAns.valid ? hostAns.code : 8'hEE;
    // Dropped fields show the inverse, never a stale copy
    hostCmd = '{1'b0, ~code, ~tgt};
    @(negedge clk);
  endtask : issue

  task automatic ack(output logic [7:0] ans);
    issue(gfs_pkg::CMD_ACK, 16'h0000, ans);
  endtask : ack
endmodule : gfs_host_model

// ---- test/gfs_supervisor_checker.sv ----
`timescale 1ns/1ps
module gfs_supervisor_checker #(
  parameter int                         LOG_DEPTH = gfs_pkg::LOG_DEPTH_DEF,
  parameter logic [gfs_pkg::VOLT_W-1:0] HYST      = gfs_pkg::HYST_DEF
) (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         reset_n,
  // Host side
  input wire gfs_pkg::gfs_cmd_t            hostCmd,
  input wire gfs_pkg::gfs_ans_t            hostAns,
  // Status
  input wire gfs_pkg::gfs_grip_t           gripState,
  input wire logic                         halt_latched_flag,
  input wire logic                         supply_fault_flag,
  input wire logic                         tempWarnFlag,
  input wire logic                         tempErrFlag,
  input wire logic                         currentFaultFlag,
  input wire logic                         drivePowerOn,
  input wire logic                         monitorActive,
  input wire logic [$clog2(LOG_DEPTH)-1:0] logWritePtr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Request classes at the taking edge
  wire isMove  = hostCmd.valid && hostCmd.code inside {gfs_pkg::CMD_PREPOS,
    gfs_pkg::CMD_GRASP, gfs_pkg::CMD_RELEASE};
  wire isAck   = hostCmd.valid && hostCmd.code == gfs_pkg::CMD_ACK;
  wire causeOn = tempErrFlag || currentFaultFlag || supply_fault_flag;
  // Accepted ack: flag drops with the answer, power back a cycle later
  sequence sAckOk;
    hostAns.valid && hostAns.code == gfs_pkg::ANS_OK && !halt_latched_flag ##1 drivePowerOn;
  endsequence
  sequence sDenied;
    hostAns.valid && hostAns.code == gfs_pkg::ANS_DENIED;
  endsequence

  AST_HALT_NO_POWER: assert property (halt_latched_flag |-> !drivePowerOn)
    else $error("drive powered while halted");
  AST_CURR_HALT: assert property ($rose(currentFaultFlag) |=> halt_latched_flag)
    else $error("current fault without halt");
  AST_TEMP_HALT: assert property ($rose(tempErrFlag) |=> halt_latched_flag && !drivePowerOn)
    else $error("temperature error without halt");
  AST_SUPPLY_HALT: assert property ($rose(supply_fault_flag) |=> halt_latched_flag)
    else $error("supply fault without halt");
  AST_MOVE_DENIED: assert property (isMove && halt_latched_flag |=> sDenied)
    else $error("move not denied while halted");
  AST_ACK_REFUSED: assert property (isAck && causeOn |=> hostAns.valid &&
    hostAns.code == gfs_pkg::ANS_REFUSED)
    else $error("ack taken while cause persists");
  AST_ACK_CLEARS: assert property (isAck && halt_latched_flag && !causeOn |=> sAckOk)
    else $error("clean ack did not clear halt");
  AST_STOP_IDLE: assert property (hostCmd.valid && hostCmd.code == gfs_pkg::CMD_STOP &&
    gripState != gfs_pkg::GS_ERROR |=> gripState == gfs_pkg::GS_IDLE)
    else $error("stop did not return to idle");
  AST_PREPOS_QUIET: assert property (gripState == gfs_pkg::GS_POSITIONING &&
    $past(gripState) == gfs_pkg::GS_POSITIONING |-> !monitorActive)
    else $error("monitor active while positioning");
  AST_WARN_WITH_ERR: assert property (tempErrFlag |-> tempWarnFlag)
    else $error("temperature error without warning");
  AST_LOG_ON_CURRENT: assert property ($rose(currentFaultFlag) |->
    ##[0:2] $changed(logWritePtr))
    else $error("current fault not logged");
endmodule : gfs_supervisor_checker

bind gfs_supervisor gfs_supervisor_checker #(.LOG_DEPTH(LOG_DEPTH), .HYST(HYST)) chk_i (
  .clk, .reset_n, .hostCmd, .hostAns, .gripState, .halt_latched_flag, .supply_fault_flag,
  .tempWarnFlag, .tempErrFlag, .currentFaultFlag, .drivePowerOn, .monitorActive, .logWritePtr);

// ---- test/gfs_supervisor_test.sv ----
`timescale 1ns/1ps
module gfs_supervisor_test;
  // Stimulus, all valued at time zero
  logic clk, reset_n = 1'b0, webAck = 1'b0, contactSeen = 1'b0, motionDone = 1'b0;
  logic forceLost = 1'b0, overCurrent = 1'b0, innerLimitOn = 1'b0, outerLimitOn = 1'b0;
  logic [15:0] nominalWidth = 16'h03E8, widthTolerance = 16'h0032, clampTravel = 16'h0064;
  logic [15:0] fullTravel = 16'h07D0, innerLimit = 16'h0000, outerLimit = 16'h0708;
  logic [15:0] fingerPos = 16'h03E8;
  logic [11:0] housingTemp = 12'h190, supplyVolt = 12'h0F0;
  logic [1:0]  logReadIdx = 2'b00, logWritePtr;
  // Observed
  logic halt_latched_flag, supply_fault_flag, supply_warning_flag, tempWarnFlag, tempErrFlag;
  logic currentFaultFlag, drivePowerOn, monitorActive, logWrapped;
  gfs_pkg::gfs_cmd_t  hostCmd;
  gfs_pkg::gfs_ans_t  hostAns;
  gfs_pkg::gfs_grip_t gripState;
  gfs_pkg::gfs_log_t  logReadData;
  int errorCnt = 0, checkCount = 0, relCyc;
  logic [7:0] ans;

  // Four slots so that wrapping is cheap to reach
  gfs_supervisor #(.LOG_DEPTH(4)) dut (.clk, .reset_n, .hostCmd, .hostAns, .webAck,
    .nominalWidth, .widthTolerance, .clampTravel, .fullTravel, .innerLimitOn, .innerLimit,
    .outerLimitOn, .outerLimit, .fingerPos, .contactSeen, .motionDone, .forceLost,
    .housingTemp, .supplyVolt, .overCurrent, .gripState, .halt_latched_flag,
    .supply_fault_flag, .supply_warning_flag, .tempWarnFlag, .tempErrFlag, .currentFaultFlag,
    .drivePowerOn, .monitorActive, .logReadIdx, .logReadData, .logWritePtr, .logWrapped);
  gfs_host_model host (.clk, .hostCmd, .hostAns);

  // 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycles since release, for the log stamp
  always @(posedge clk) relCyc <= reset_n ? relCyc + 1 : 0;

  task automatic printVerdict();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : printVerdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: check %0d got %0h exp %0h", $time, checkCount, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic cmd(input logic [7:0] code, input logic [15:0] tgt, input logic [7:0] exp);
    host.issue(code, tgt, ans);
    chk(ans, exp);
  endtask : cmd
  task automatic ack(input logic [7:0] exp);
    host.ack(ans);
    chk(ans, exp);
  endtask : ack
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  // Three edges after release flush the pin stages
  task automatic doReset();
    reset_n = 1'b0;
    tick(5);
    reset_n = 1'b1;
    tick(3);
  endtask : doReset

  task automatic testGrasp();
    cmd(gfs_pkg::CMD_GRASP, nominalWidth, gfs_pkg::ANS_OK);
    chk(gripState, gfs_pkg::GS_GRASPING);
    pulse(motionDone);
    chk(gripState, gfs_pkg::GS_NO_PART);
    cmd(gfs_pkg::CMD_STOP, 16'h0000, gfs_pkg::ANS_OK);
    cmd(gfs_pkg::CMD_GRASP, nominalWidth, gfs_pkg::ANS_OK);
    // 980 lies inside 850..1050
    fingerPos = 16'h03D4;
    contactSeen = 1'b1;
    tick(4);
    pulse(motionDone);
    chk(gripState, gfs_pkg::GS_HOLDING);
    chk(monitorActive, 1'b1);
    contactSeen = 1'b0;
    cmd(gfs_pkg::CMD_STOP, 16'h0000, gfs_pkg::ANS_OK);
    chk(gripState, gfs_pkg::GS_IDLE);
    // 1200 is beyond the window
    cmd(gfs_pkg::CMD_GRASP, nominalWidth, gfs_pkg::ANS_OK);
    fingerPos = 16'h04B0;
    contactSeen = 1'b1;
    tick(4);
    chk(gripState, gfs_pkg::GS_ERROR);
    contactSeen = 1'b0;
    // Mid-run reset: a block need not be cleared by ack
    doReset();
    chk(drivePowerOn, 1'b1);
    // Full-range tolerance: outside contact must not block
    widthTolerance = fullTravel;
    cmd(gfs_pkg::CMD_GRASP, nominalWidth, gfs_pkg::ANS_OK);
    fingerPos = 16'h0FA0;
    contactSeen = 1'b1;
    tick(4);
    chk(gripState, gfs_pkg::GS_GRASPING);
    cmd(gfs_pkg::CMD_STOP, 16'h0000, gfs_pkg::ANS_OK);
    contactSeen = 1'b0;
  endtask : testGrasp

  task automatic testPrepos();
    cmd(gfs_pkg::CMD_PREPOS, 16'h04B0, gfs_pkg::ANS_OK);
    contactSeen = 1'b1;
    forceLost = 1'b1;
    tick(4);
    chk(gripState, gfs_pkg::GS_POSITIONING);
    chk(monitorActive, 1'b0);
    contactSeen = 1'b0;
    forceLost = 1'b0;
    pulse(motionDone);
    chk(gripState, gfs_pkg::GS_IDLE);
  endtask : testPrepos

  task automatic testLimits();
    // Zones below 300 and above 1800; start inside the inner one
    innerLimit = 16'h012C;
    fingerPos = 16'h0064;
    tick(4);
    innerLimitOn = 1'b1;
    outerLimitOn = 1'b1;
    tick(4);
    cmd(gfs_pkg::CMD_PREPOS, 16'h0032, gfs_pkg::ANS_RANGE);
    cmd(gfs_pkg::CMD_PREPOS, 16'h03E8, gfs_pkg::ANS_OK);
    fingerPos = 16'h03E8;
    tick(4);
    pulse(motionDone);
    cmd(gfs_pkg::CMD_PREPOS, 16'h0064, gfs_pkg::ANS_RANGE);
    cmd(gfs_pkg::CMD_PREPOS, 16'h07D0, gfs_pkg::ANS_RANGE);
    cmd(gfs_pkg::CMD_PREPOS, 16'h0320, gfs_pkg::ANS_OK);
    fingerPos = 16'h00FA;
    tick(5);
    chk(halt_latched_flag, 1'b1);
    chk(drivePowerOn, 1'b0);
    cmd(gfs_pkg::CMD_GRASP, nominalWidth, gfs_pkg::ANS_DENIED);
    fingerPos = 16'h0190;
    tick(4);
    ack(gfs_pkg::ANS_OK);
    tick(1);
    chk(drivePowerOn, 1'b1);
    innerLimitOn = 1'b0;
    outerLimitOn = 1'b0;
  endtask : testLimits

  task automatic testTemp();
    housingTemp = gfs_pkg::TEMP_WARN;
    tick(4);
    chk(tempWarnFlag, 1'b0);
    housingTemp = 12'h28B;
    tick(4);
    chk(tempWarnFlag, 1'b1);
    housingTemp = gfs_pkg::TEMP_ERR;
    tick(5);
    chk(halt_latched_flag, 1'b1);
    ack(gfs_pkg::ANS_REFUSED);
    housingTemp = 12'h258;
    tick(4);
    chk(tempErrFlag, 1'b0);
    ack(gfs_pkg::ANS_OK);
  endtask : testTemp

  task automatic testSupply();
    // 24.0, 22.0, 22.3, 22.6, 20.0, 26.0, 28.0, 24.0 V; warn and fault
    logic [11:0] v [8] = '{12'h0F0, 12'h0DC, 12'h0DF, 12'h0E2, 12'h0C8, 12'h104, 12'h118, 12'h0F0};
    logic [1:0]  e [8] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b11, 2'b10, 2'b11, 2'b00};
    for (int i = 0; i < 8; i++) begin
      supplyVolt = v[i];
      tick(5);
      chk(supply_warning_flag, e[i][1]);
      chk(supply_fault_flag, e[i][0]);
      if (e[i][0]) ack(gfs_pkg::ANS_REFUSED);
    end
    chk(halt_latched_flag, 1'b1);
    ack(gfs_pkg::ANS_OK);
  endtask : testSupply

  task automatic testCurrent();
    logic [1:0] p;
    int ms;
    // Let the millisecond stamp move off zero
    tick(12000);
    for (int i = 0; i < 2; i++) begin
      p = logWritePtr;
      overCurrent = 1'b1;
      tick(5);
      ms = relCyc / 10000;
      chk(currentFaultFlag, 1'b1);
      chk(drivePowerOn, 1'b0);
      logReadIdx = p;
      p = p + 1'b1;
      chk(logWritePtr, p);
      ack(gfs_pkg::ANS_REFUSED);
      chk(logReadData.cause, gfs_pkg::EV_CURR);
      chk(32'(logReadData.stamp + 1 >= ms && logReadData.stamp <= ms), 1);
      overCurrent = 1'b0;
      tick(4);
      pulse(webAck);
      chk(halt_latched_flag, 1'b0);
    end
    chk(logWrapped, 1'b1);
  endtask : testCurrent

  initial begin
    doReset();
    chk(halt_latched_flag, 1'b0);
    testGrasp();
    testPrepos();
    testLimits();
    testTemp();
    testSupply();
    testCurrent();
    printVerdict();
  end
  // Runs well past the expected span of about 12200 cycles
  initial begin
    repeat (30000) @(posedge clk);
    errorCnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    printVerdict();
  end
endmodule : gfs_supervisor_test
